// [pkg/ppp_pkg.sv]
`default_nettype none
// ============================================================
// Constants for the parallel programming host
package ppp_pkg;

  // ==========================================================
  // Clock and pin timing
  localparam int CLK_MHZ         = 250;
  localparam int T_SETUP_NS      = 40;   // Pins settle before a pulse
  localparam int T_PULSE_NS      = 100;  // Strobe or write pulse width
  localparam int T_HOLD_NS       = 40;   // Pins held after a pulse
  localparam int T_ACCESS_NS     = 120;  // Output enable low to sample
  localparam int T_BUSY_GUARD_NS = 200;  // Wait for busy to appear

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC  = ns_to_cyc(T_SETUP_NS);
  localparam int PULSE_CYC  = ns_to_cyc(T_PULSE_NS);
  localparam int HOLD_CYC   = ns_to_cyc(T_HOLD_NS);
  localparam int ACCESS_CYC = ns_to_cyc(T_ACCESS_NS);
  localparam int GUARD_CYC  = ns_to_cyc(T_BUSY_GUARD_NS);
  localparam int CNT_W      = 12;

  // ==========================================================
  // Register map of the host
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_XA_LSB   = 8;
  localparam int CTRL_BS1_BIT  = 12;
  localparam int CTRL_BS2_BIT  = 13;
  localparam int CTRL_DATA_LSB = 16;

  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_READY_BIT   = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_RDATA_LSB   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================
  // Host operations
  typedef enum logic [2:0] {
    OP_LOAD    = 3'h0,
    OP_LATCH   = 3'h1,
    OP_PROGRAM = 3'h2,
    OP_READ    = 3'h3,
    OP_END     = 3'h4
  } op_t;

  // Action select codes on a crystal strobe
  localparam logic [1:0] XA_ADDR = 2'h0;
  localparam logic [1:0] XA_DATA = 2'h1;
  localparam logic [1:0] XA_CMD  = 2'h2;
  localparam logic [1:0] XA_IDLE = 2'h3;

  // Command bytes of the device
  localparam logic [7:0] CMD_NOP          = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h80;
  localparam logic [7:0] CMD_WRITE_FUSE   = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK   = 8'h20;
  localparam logic [7:0] CMD_WRITE_FLASH  = 8'h10;
  localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
  localparam logic [7:0] CMD_READ_ID      = 8'h08;
  localparam logic [7:0] CMD_READ_FUSE    = 8'h04;
  localparam logic [7:0] CMD_READ_FLASH   = 8'h02;
  localparam logic [7:0] CMD_READ_EEPROM  = 8'h03;

  // ==========================================================
  // Pin sequencer states
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_READY = 6'h02,
    S_SETUP = 6'h04,
    S_PULSE = 6'h08,
    S_BUSY  = 6'h10,
    S_HOLD  = 6'h20
  } state_t;

endpackage
`default_nettype wire

// [pkg/ppp_cmd_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Order and status between the register bank and the sequencer
interface ppp_cmd_if;
  logic             start;
  ppp_pkg::op_t     op;
  logic [1:0]       xa;
  logic             bs1;
  logic             bs2;
  logic [7:0]       data;
  logic             busy;
  logic             ready;
  logic [7:0]       rd_data;

  modport regs (output start, op, xa, bs1, bs2, data,
                input  busy, ready, rd_data);
  modport seq  (input  start, op, xa, bs1, bs2, data,
                output busy, ready, rd_data);
endinterface
`default_nettype wire

// [rtl/ppp_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// AXI4-Lite register bank of the programming host
module ppp_regs (
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  // AXI4-Lite slave
  input  wire logic [ppp_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                      i_awvalid,
  output logic                           o_awready,
  input  wire logic [31:0]               i_wdata,
  input  wire logic [3:0]                i_wstrb,
  input  wire logic                      i_wvalid,
  output logic                           o_wready,
  output logic [1:0]                     o_bresp,
  output logic                           o_bvalid,
  input  wire logic                      i_bready,
  input  wire logic [ppp_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                      i_arvalid,
  output logic                           o_arready,
  output logic [31:0]                    o_rdata,
  output logic [1:0]                     o_rresp,
  output logic                           o_rvalid,
  input  wire logic                      i_rready,
  // Orders to the sequencer
  ppp_cmd_if.regs                        cmd
);
  logic [ppp_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic                       aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0]                wdata_q, wdata_d, ctrl_q, ctrl_d;
  logic [3:0]                 wstrb_q, wstrb_d;
  logic                       bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       start_q, start_d, refused_q, refused_d;
  logic                       busy_all;
  logic                       awready_q, awready_d, wready_q, wready_d;
  logic                       arready_q, arready_d;

  // Status word as software sees it
  function automatic logic [31:0] status_word(input logic busy,
      input logic rdy, input logic refd, input logic [7:0] rd);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[ppp_pkg::STAT_BUSY_BIT]    = busy;
    s[ppp_pkg::STAT_READY_BIT]   = rdy;
    s[ppp_pkg::STAT_REFUSED_BIT] = refd;
    s[ppp_pkg::STAT_RDATA_LSB +: 8] = rd;
    return s;
  endfunction

  assign busy_all = cmd.busy | start_q;

  // Next state of the bus slave and the control register
  always_comb begin
    awaddr_d  = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    w_have_d  = w_have_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    ctrl_d    = ctrl_q;
    start_d   = 1'b0;
    refused_d = refused_q;
    if (i_awvalid && o_awready) begin
      awaddr_d  = i_awaddr;
      aw_have_d = 1'b1;
    end
    if (i_wvalid && o_wready) begin
      wdata_d  = i_wdata;
      wstrb_d  = i_wstrb;
      w_have_d = 1'b1;
    end
    if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    // Both halves held: perform the write
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = ppp_pkg::RESP_OKAY;
      if (awaddr_q == ppp_pkg::REG_CTRL) begin
        if (busy_all) begin
          refused_d = 1'b1;
        end else begin
          for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b]) begin
              ctrl_d[b*8 +: 8] = wdata_q[b*8 +: 8];
            end
          end
          start_d = wstrb_q[0];
        end
      end else if (awaddr_q == ppp_pkg::REG_STATUS) begin
        if (wstrb_q[0] && wdata_q[ppp_pkg::STAT_REFUSED_BIT]) begin
          refused_d = 1'b0;
        end
      end else begin
        bresp_d = ppp_pkg::RESP_DECERR;
      end
    end
    // A refusal in the clearing cycle is kept
    if (aw_have_q && w_have_q && !bvalid_q && busy_all &&
        awaddr_q == ppp_pkg::REG_CTRL) begin
      refused_d = 1'b1;
    end
    if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = ppp_pkg::RESP_OKAY;
      case (i_araddr)
        ppp_pkg::REG_CTRL:   rdata_d = ctrl_q;
        ppp_pkg::REG_STATUS: rdata_d = status_word(busy_all, cmd.ready,
                                                   refused_q, cmd.rd_data);
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = ppp_pkg::RESP_DECERR;
        end
      endcase
    end
    // Ready flags follow the held halves and the pending answers
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  // Register the bus slave
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      awaddr_q  <= '0;
      aw_have_q <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ppp_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= ppp_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      ctrl_q    <= ppp_pkg::CTRL_RESET;
      start_q   <= 1'b0;
      refused_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      awaddr_q  <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      w_have_q  <= w_have_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      start_q   <= start_d;
      refused_q <= refused_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
    end
  end

  // Bus outputs and the order fields
  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rvalid_q;
  assign o_rresp   = rresp_q;
  assign o_rdata   = rdata_q;
  assign cmd.start = start_q;
  assign cmd.op    = ppp_pkg::op_t'(ctrl_q[ppp_pkg::CTRL_OP_LSB +: 3]);
  assign cmd.xa    = ctrl_q[ppp_pkg::CTRL_XA_LSB +: 2];
  assign cmd.bs1   = ctrl_q[ppp_pkg::CTRL_BS1_BIT];
  assign cmd.bs2   = ctrl_q[ppp_pkg::CTRL_BS2_BIT];
  assign cmd.data  = ctrl_q[ppp_pkg::CTRL_DATA_LSB +: 8];
endmodule // ppp_regs
`default_nettype wire

// [rtl/parallel_program_host.sv]
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host that drives the parallel programming port of the device

// Behaviour
// - Load data low: action select 01, byte on bus, positive crystal strobe.
// - Load data high: byte_select_1 high, action select 01, crystal strobe.
// - With byte_select_1 high, latch strobe copies data into the page buffer.
// - Load address high: action select 00, byte_select_1 high, crystal strobe.
// - Low program pulse writes the flash page; wait for ready high again.
// - Software repeats address, data, latch and program steps per page.
// - End page programming by loading command 0x00 with action select 10.
// - EEPROM write: command 0x11, address high, then address, data, latch.
// - EEPROM page: byte_select_1 low, program pulse, wait for ready.
// - Fuse write: command 0x40, data low, program pulse, wait for ready.
// - Fuse high: byte_select_1 1, byte_select_2 0 around the pulse.
// - Extended fuse: byte_select_1 0, byte_select_2 1 around the pulse.
module parallel_program_host #(
  parameter int SETUP_CYC  = ppp_pkg::SETUP_CYC,
  parameter int PULSE_CYC  = ppp_pkg::PULSE_CYC,
  parameter int HOLD_CYC   = ppp_pkg::HOLD_CYC,
  parameter int ACCESS_CYC = ppp_pkg::ACCESS_CYC,
  parameter int GUARD_CYC  = ppp_pkg::GUARD_CYC
) (
  // Clock and reset
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  // AXI4-Lite slave
  input  wire logic [ppp_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [ppp_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  // Device control pins
  output logic                            o_action_select_0,
  output logic                            o_action_select_1,
  output logic                            o_byte_select_1,
  output logic                            o_byte_select_2,
  output logic                            o_crystal_strobe,
  output logic                            o_buffer_latch_strobe,
  output logic                            o_program_pulse_n,
  output logic                            o_output_enable_n,
  input  wire logic                       i_ready_busy_n,
  // Two-way data bus
  input  wire logic [7:0]                 i_data,
  output logic [7:0]                      o_data,
  output logic                            o_data_oe
);
  // ==========================================================
  // Elaboration checks
  localparam int CMAX = (1 << ppp_pkg::CNT_W) - 1;
  if (SETUP_CYC < 1 || SETUP_CYC > CMAX || PULSE_CYC < 1 ||
      PULSE_CYC > CMAX || HOLD_CYC < 1 || HOLD_CYC > CMAX ||
      ACCESS_CYC < 3 || ACCESS_CYC > CMAX || GUARD_CYC < 1 ||
      GUARD_CYC > CMAX) begin : g_bad_timing
    $error("parallel_program_host: timing count out of range");
  end

  // ==========================================================
  // Register bank
  ppp_cmd_if cmd ();

  ppp_regs u_regs (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .cmd       (cmd.regs)
  );

  // ==========================================================
  // Pin input synchronisers
  logic       rdy_meta_q, rdy_sync_q;
  logic [7:0] dat_meta_q, dat_sync_q;

  // Two flops on the ready line and the data bus
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdy_meta_q <= 1'b0;
      rdy_sync_q <= 1'b0;
      dat_meta_q <= 8'h00;
      dat_sync_q <= 8'h00;
    end else begin
      rdy_meta_q <= i_ready_busy_n;
      rdy_sync_q <= rdy_meta_q;
      dat_meta_q <= i_data;
      dat_sync_q <= dat_meta_q;
    end
  end

  // ==========================================================
  // Pin sequencer
  ppp_pkg::state_t            state_q, state_d;
  ppp_pkg::op_t               op_q, op_d;
  logic [ppp_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic [1:0]                 xa_q, xa_d;
  logic                       bs1_q, bs1_d, bs2_q, bs2_d;
  logic                       xs_q, xs_d, ls_q, ls_d, pp_n_q, pp_n_d;
  logic                       oe_n_q, oe_n_d, doe_q, doe_d;
  logic [7:0]                 dout_q, dout_d, rd_q, rd_d;

  // Count load for a cycle figure
  function automatic logic [ppp_pkg::CNT_W-1:0] cload(input int cyc);
    return ppp_pkg::CNT_W'(cyc - 1);
  endfunction

  // Next pin state and sequencing
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    cnt_d   = cnt_q;
    xa_d    = xa_q;
    bs1_d   = bs1_q;
    bs2_d   = bs2_q;
    xs_d    = xs_q;
    ls_d    = ls_q;
    pp_n_d  = pp_n_q;
    oe_n_d  = oe_n_q;
    doe_d   = doe_q;
    dout_d  = dout_q;
    rd_d    = rd_q;
    case (state_q)
      ppp_pkg::S_IDLE: begin
        if (cmd.start) begin
          op_d    = cmd.op;
          bs1_d   = cmd.bs1;
          bs2_d   = cmd.bs2;
          xa_d    = cmd.xa;
          dout_d  = cmd.data;
          doe_d   = 1'b0;
          state_d = ppp_pkg::S_READY;
          case (cmd.op)
            ppp_pkg::OP_LOAD:  doe_d = 1'b1;
            ppp_pkg::OP_LATCH: bs1_d = 1'b1;
            ppp_pkg::OP_END: begin
              xa_d   = ppp_pkg::XA_CMD;
              dout_d = ppp_pkg::CMD_NOP;
              doe_d  = 1'b1;
            end
            ppp_pkg::OP_PROGRAM, ppp_pkg::OP_READ: ;
            default: state_d = ppp_pkg::S_IDLE;
          endcase
          if (cmd.op != ppp_pkg::OP_LOAD && cmd.op != ppp_pkg::OP_END) begin
            xa_d = ppp_pkg::XA_IDLE;
          end
        end
      end
      ppp_pkg::S_READY: begin
        // Wait for the device to be ready before any pulse
        if (rdy_sync_q) begin
          if (op_q == ppp_pkg::OP_READ) begin
            oe_n_d = 1'b0;
            cnt_d  = cload(ACCESS_CYC);
          end else begin
            cnt_d  = cload(SETUP_CYC);
          end
          state_d = ppp_pkg::S_SETUP;
        end
      end
      ppp_pkg::S_SETUP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (op_q == ppp_pkg::OP_READ) begin
          rd_d    = dat_sync_q;
          oe_n_d  = 1'b1;
          cnt_d   = cload(HOLD_CYC);
          state_d = ppp_pkg::S_HOLD;
        end else begin
          case (op_q)
            ppp_pkg::OP_LATCH:   ls_d   = 1'b1;
            ppp_pkg::OP_PROGRAM: pp_n_d = 1'b0;
            default:             xs_d   = 1'b1;
          endcase
          cnt_d   = cload(PULSE_CYC);
          state_d = ppp_pkg::S_PULSE;
        end
      end
      ppp_pkg::S_PULSE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          xs_d   = 1'b0;
          ls_d   = 1'b0;
          pp_n_d = 1'b1;
          if (op_q == ppp_pkg::OP_PROGRAM) begin
            cnt_d   = cload(GUARD_CYC);
            state_d = ppp_pkg::S_BUSY;
          end else begin
            cnt_d   = cload(HOLD_CYC);
            state_d = ppp_pkg::S_HOLD;
          end
        end
      end
      ppp_pkg::S_BUSY: begin
        // Let busy show, then wait until the page is written
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (rdy_sync_q) begin
          cnt_d   = cload(HOLD_CYC);
          state_d = ppp_pkg::S_HOLD;
        end
      end
      ppp_pkg::S_HOLD: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          doe_d   = 1'b0;
          state_d = ppp_pkg::S_IDLE;
        end
      end
      default: state_d = ppp_pkg::S_IDLE;
    endcase
  end

  // Register the sequencer and every pin
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ppp_pkg::S_IDLE;
      op_q    <= ppp_pkg::OP_LOAD;
      cnt_q   <= '0;
      xa_q    <= ppp_pkg::XA_IDLE;
      bs1_q   <= 1'b0;
      bs2_q   <= 1'b0;
      xs_q    <= 1'b0;
      ls_q    <= 1'b0;
      pp_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      doe_q   <= 1'b0;
      dout_q  <= 8'h00;
      rd_q    <= 8'h00;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      xa_q    <= xa_d;
      bs1_q   <= bs1_d;
      bs2_q   <= bs2_d;
      xs_q    <= xs_d;
      ls_q    <= ls_d;
      pp_n_q  <= pp_n_d;
      oe_n_q  <= oe_n_d;
      doe_q   <= doe_d;
      dout_q  <= dout_d;
      rd_q    <= rd_d;
    end
  end

  // Status back to the register bank
  assign cmd.busy    = (state_q != ppp_pkg::S_IDLE);
  assign cmd.ready   = rdy_sync_q;
  assign cmd.rd_data = rd_q;

  // Pins straight from flops
  assign o_action_select_0     = xa_q[0];
  assign o_action_select_1     = xa_q[1];
  assign o_byte_select_1       = bs1_q;
  assign o_byte_select_2       = bs2_q;
  assign o_crystal_strobe      = xs_q;
  assign o_buffer_latch_strobe = ls_q;
  assign o_program_pulse_n     = pp_n_q;
  assign o_output_enable_n     = oe_n_q;
  assign o_data                = dout_q;
  assign o_data_oe             = doe_q;
endmodule // parallel_program_host
`default_nettype wire

// [dv/ppp_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Device behind the programming pins
module ppp_dev_model (
  // Pins from the host
  input wire logic i_clock, o_action_select_0, o_action_select_1,
  input wire logic o_byte_select_1, o_crystal_strobe, o_data_oe,
  input wire logic o_buffer_latch_strobe, o_program_pulse_n,
  input wire logic o_output_enable_n,
  input wire logic [7:0] o_data,
  // Pins to the host
  output logic i_ready_busy_n,
  output logic [7:0] i_data
);
  logic [7:0] cmd = 8'h00, ah, al, dl, dh, pb, tog = 8'h00;
  logic [7:0] mem [16];
  logic xs_q = 1'b0, pl_q = 1'b0, wr_q = 1'b1;
  int bc = 0;
  // Strobe edges capture bytes, a write pulse starts busy time
  always @(posedge i_clock) begin
    xs_q <= o_crystal_strobe;
    pl_q <= o_buffer_latch_strobe;
    wr_q <= o_program_pulse_n;
    tog <= tog + 8'h01;
    if (o_crystal_strobe && !xs_q)
      case ({o_action_select_1, o_action_select_0})
        2'b00: if (o_byte_select_1) ah <= o_data; else al <= o_data;
        2'b01: if (o_byte_select_1) dh <= o_data; else dl <= o_data;
        2'b10: cmd <= o_data;
        default: ;
      endcase
    if (o_buffer_latch_strobe && !pl_q && o_byte_select_1) pb <= dl;
    if (!o_program_pulse_n && wr_q) begin
      bc <= 12;
      if (cmd == 8'h11) mem[al[3:0]] <= pb;
    end else if (bc > 0) bc <= bc - 1;
  end
  // Busy pin; a bus nobody drives shows a changing value
  assign i_ready_busy_n = (bc == 0);
  assign i_data = o_data_oe ? o_data : (!o_output_enable_n &&
    cmd == 8'h03 && !o_byte_select_1) ? mem[al[3:0]] : tog;
endmodule // ppp_dev_model
`default_nettype wire

// [dv/parallel_program_host_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Pin and bus checks on the programming host
module ppp_host_assertions #(parameter int PULSE_CYC = 1) (
  input wire logic i_clock, i_rst, i_bready, i_arvalid, o_arready,
  input wire logic o_bvalid, o_rvalid, o_crystal_strobe, o_data_oe,
  input wire logic o_output_enable_n, o_action_select_0,
  input wire logic o_action_select_1, o_byte_select_1,
  input wire logic o_buffer_latch_strobe, o_program_pulse_n,
  input wire logic i_ready_busy_n,
  input wire logic [1:0] o_bresp,
  input wire logic [7:0] o_data
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [7:0] lo_q;
  // Cycles the write pulse has been low
  always_ff @(posedge i_clock)
    lo_q <= (i_rst || o_program_pulse_n) ? 8'h00 : lo_q + 8'h01;
  property p_xs; o_crystal_strobe |-> o_data_oe; endproperty
  a_xs: assert property (p_xs) else $error("bus idle in strobe");
  property p_hold; o_crystal_strobe && $past(o_crystal_strobe) |->
    $stable({o_action_select_1, o_action_select_0, o_data}); endproperty
  a_hold: assert property (p_hold) else $error("pins moved");
  property p_pl; o_buffer_latch_strobe |-> o_byte_select_1; endproperty
  a_pl: assert property (p_pl) else $error("latch select");
  property p_wr; !o_program_pulse_n |->
    {o_action_select_1, o_action_select_0} == 2'b11; endproperty
  a_wr: assert property (p_wr) else $error("write select");
  property p_len; $rose(o_program_pulse_n) |-> lo_q == PULSE_CYC;
  endproperty
  a_len: assert property (p_len) else $error("pulse length");
  property p_oe; !o_output_enable_n |-> !o_data_oe; endproperty
  a_oe: assert property (p_oe) else $error("bus clash");
  property p_rdy; $rose(o_crystal_strobe) || $fell(o_program_pulse_n)
    || $rose(o_buffer_latch_strobe) |-> $past(i_ready_busy_n);
  endproperty
  a_rdy: assert property (p_rdy) else $error("strobe in busy");
  property p_b; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b: assert property (p_b) else $error("response dropped");
  property p_r; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_r: assert property (p_r) else $error("read late");
endmodule // ppp_host_assertions
`default_nettype wire

// [dv/parallel_program_host_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench of the programming host
module parallel_program_host_test;
  logic i_clock = 1'b0, i_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
  logic [31:0] i_wdata = 32'h0, o_rdata, rd;
  logic [1:0] o_bresp, o_rresp, rr;
  logic [7:0] i_data, o_data;
  logic i_ready_busy_n, o_awready, o_wready, o_bvalid, o_arready;
  logic o_rvalid, o_data_oe, o_action_select_0, o_action_select_1;
  logic o_byte_select_1, o_byte_select_2, o_crystal_strobe;
  logic o_buffer_latch_strobe, o_program_pulse_n, o_output_enable_n;
  int error_cnt = 0, total_checks = 0, n;
  // Pin levels of the host, compared after each reset
  logic [8:0] pins;
  assign pins = {o_action_select_1, o_action_select_0, o_byte_select_1,
    o_byte_select_2, o_crystal_strobe, o_buffer_latch_strobe,
    o_program_pulse_n, o_output_enable_n, o_data_oe};
  // Control word, expected status, compared status bits
  logic [63:0] rows [8] = '{64'h0011_0200_0002_0007,
    64'h0000_1000_0002_0007, 64'h0005_0000_0002_0007,
    64'h003C_0100_0002_0007, 64'h0000_0001_0002_0007,
    64'h0000_0002_0002_0007, 64'h0003_0200_0002_0007,
    64'h0000_0003_3C02_FF07};
  parallel_program_host #(.SETUP_CYC(1), .PULSE_CYC(2), .HOLD_CYC(1),
    .ACCESS_CYC(5), .GUARD_CYC(8)) i_parallel_program_host (.*);
  ppp_dev_model i_ppp_dev_model (.*);
  // Clock
  always #2 i_clock = ~i_clock;
  task automatic results;
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One clock of a bounded wait
  task automatic tick;
    @(posedge i_clock);
    n++;
    if (n > 2000) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    n = 0;
    i_awaddr <= a;
    i_wdata <= d;
    {i_awvalid, i_wvalid} <= 2'h3;
    do begin
      tick();
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (i_awvalid || i_wvalid);
    tick();
    i_bready <= 1'b1;
    do tick(); while (!o_bvalid);
    rr = o_bresp;
    i_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge i_clock);
    i_araddr <= a;
    {i_arvalid, i_rready} <= 2'h3;
    do tick(); while (!o_arready);
    i_arvalid <= 1'b0;
    do tick(); while (!o_rvalid);
    rd = o_rdata;
    rr = o_rresp;
    i_rready <= 1'b0;
  endtask
  // Poll status until the pin sequence is over
  task automatic idle;
    do rd_reg(4'h4); while (rd[0] !== 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    chk(32'(pins), 32'h186);
    rd_reg(4'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, rows[i][63:32]);
      idle();
      chk(32'(rd[15:0] & rows[i][15:0]), 32'(rows[i][31:16]));
    end
    rd_reg(4'h8);
    chk(32'(rr), 32'h3);
    wr(4'h8, 32'h1);
    chk(32'(rr), 32'h3);
    wr(4'h0, 32'h2002);
    wr(4'h0, 32'h2);
    chk(32'(rr), 32'h0);
    idle();
    chk(32'(rd[2:0]), 32'h6);
    chk(32'(o_byte_select_2), 32'h1);
    wr(4'h4, 32'h4);
    rd_reg(4'h4);
    chk(32'(rd[2:0]), 32'h2);
    // Reset in the middle of a load
    wr(4'h0, 32'h0011_0200);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    chk(32'(pins), 32'h186);
    rd_reg(4'h0);
    chk(rd, 32'h0);
    wr(4'h0, 32'h4);
    idle();
    chk(32'(i_ppp_dev_model.cmd), 32'h0);
    results();
  end
endmodule // parallel_program_host_test
bind parallel_program_host ppp_host_assertions
  #(.PULSE_CYC(PULSE_CYC)) i_chk (.*);
`default_nettype wire
